// ===== logic/seac_ctrl.sv
// Register-driven serial EEPROM access over the master bus, with bus control settings
`timescale 1ns/100ps
`include "seac_defs.svh"

// Operation
// - Prescaler clock period is 32 ns times field
// - Prescaler value zero or one stops clock
// - Prescaler resets to 0x0053, sticky
// - Bus clock low at least half period
// - Ignore-masters bit continues despite lost arbitration
// - Checksum-ignore bit suppresses checksum errors
// - Timeout-disable bit disables master and slave timeouts
// - Data field write starts read or write
// - Write stores the written data byte
// - Read ignores written byte, returns fetched byte
// - Busy flag high while operation runs
// - Done set on completion, write-one clears
// - Select bit: zero write, one read
module seac_ctrl
	import seac_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h50,
	parameter int unsigned TIMEOUT_CYCLES = `SEAC_TIMEOUT_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic [11:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [31:0] rd_data_o,
	output logic irq_o,
	input wire logic master_bus_clock_pin_i,
	output logic master_bus_clock_pin_o,
	output logic master_bus_clock_pin_oe_o,
	input wire logic master_bus_data_pin_i,
	output logic master_bus_data_pin_o,
	output logic master_bus_data_pin_oe_o,
	input wire logic init_check_err_i,
	output logic init_check_err_o,
	output logic timeout_disable_o
);
	localparam logic [2:0] BASE_LAST = 3'(`SEAC_BASE_CYC - 1);
	localparam logic [22:0] TMO_LAST = 23'(TIMEOUT_CYCLES - 1);

	// ==========================================================
	// Helpers
	function automatic logic [15:0] low_len(input logic [15:0] pr);
		low_len = 16'(pr - (pr >> 1));
	endfunction

	function automatic seac_slot_t kind_of(input seac_seq_t s);
		case (s)
			S_START, S_RSTART: kind_of = SL_START;
			S_STOP: kind_of = SL_STOP;
			default: kind_of = SL_BIT;
		endcase
	endfunction

	function automatic logic tx_bit(input seac_seq_t s, input logic [3:0] c, input logic [7:0] sh);
		tx_bit = (s == S_RDATA || c == 4'h8) ? 1'b1 : sh[7];
	endfunction

	// Data line pulled low at slot position p; bits hold over position 0
	function automatic logic want_low(input seac_slot_t k, input logic [15:0] p, input logic [15:0] pr,
		input logic b, input logic prev);
		logic [15:0] mid;
		mid = 16'(low_len(pr) + (pr >> 2));
		case (k)
			SL_START: want_low = p >= mid;
			SL_STOP: want_low = p < mid;
			default: want_low = (p == 16'h0) ? prev : !b;
		endcase
	endfunction

	// ==========================================================
	// Pin synchronisers and 32 ns time base
	logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
	logic [2:0] base_q, base_d;
	logic tick;

	always_comb begin
		base_d = (base_q == BASE_LAST) ? 3'h0 : 3'(base_q + 3'h1);
	end

	assign tick = base_q == BASE_LAST;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			base_q <= 3'h0;
		end else begin
			scl_m_q <= master_bus_clock_pin_i;
			scl_s_q <= scl_m_q;
			sda_m_q <= master_bus_data_pin_i;
			sda_s_q <= sda_m_q;
			base_q <= base_d;
		end
	end

	// ==========================================================
	// Registers and transfer engine
	seac_seq_t seq_q, seq_d;
	logic [15:0] presc_q, presc_d, addr_q, addr_d, pos_q, pos_d;
	logic iom_q, iom_d, ics_q, ics_d, tod_q, tod_d;
	logic [7:0] data_q, data_d, sh_q, sh_d;
	logic op_q, op_d, done_q, done_d;
	logic [3:0] cnt_q, cnt_d;
	logic [`SEAC_EV_MSB:0] ist_q, ist_d, imask_q, imask_d, ev;
	logic [22:0] tmo_q, tmo_d;
	logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d, chk_q, chk_d;
	logic [31:0] rd_q, rd_d;
	logic wr_ctl, wr_ee, wr_ist, wr_imask, run, stretch, busy;

	assign wr_ctl = wr_en_i && addr_i == `SEAC_OFS_BUS_CTRL;
	assign wr_ee = wr_en_i && addr_i == `SEAC_OFS_EE_ACC;
	assign wr_ist = wr_en_i && addr_i == `SEAC_OFS_IRQ_STAT;
	assign wr_imask = wr_en_i && addr_i == `SEAC_OFS_IRQ_MASK;
	assign busy = seq_q != S_IDLE;
	assign run = presc_q > 16'h1;
	// Another party holds the clock low while we release it
	assign stretch = busy && pos_q >= low_len(presc_q) && !scl_s_q;

	always_comb begin
		seq_d = seq_q;
		presc_d = presc_q;
		iom_d = iom_q;
		ics_d = ics_q;
		tod_d = tod_q;
		addr_d = addr_q;
		data_d = data_q;
		op_d = op_q;
		pos_d = pos_q;
		sh_d = sh_q;
		cnt_d = cnt_q;
		imask_d = imask_q;
		ev = '0;
		rd_d = 32'h0;
		if (wr_ctl) begin
			presc_d = wr_data_i[`SEAC_PRESC_MSB:0];
			iom_d = wr_data_i[`SEAC_IOM_BIT];
			ics_d = wr_data_i[`SEAC_ICS_BIT];
			tod_d = wr_data_i[`SEAC_TOD_BIT];
		end
		if (wr_imask) begin
			imask_d = wr_data_i[`SEAC_EV_MSB:0];
		end
		tmo_d = (stretch && run) ? 23'(tmo_q + 23'h1) : 23'h0;
		if (seq_q == S_IDLE) begin
			// Address, data and select writes to the access register while busy are dropped; the done clear still applies
			if (wr_ee) begin
				addr_d = wr_data_i[`SEAC_ADDR_MSB:0];
				data_d = wr_data_i[`SEAC_DATA_MSB:`SEAC_DATA_LSB];
				op_d = wr_data_i[`SEAC_OP_BIT];
				seq_d = S_START;
				pos_d = 16'h0;
				cnt_d = 4'h0;
			end
		end else if (stretch && run && !tod_q && tmo_q >= TMO_LAST) begin
			seq_d = S_IDLE;
			ev[`SEAC_EV_TMO] = 1'b1;
			ev[`SEAC_EV_DONE] = 1'b1;
		end else if (tick && run && !stretch) begin
			if (pos_q < 16'(presc_q - 16'h1)) begin
				pos_d = 16'(pos_q + 16'h1);
			end else begin
				pos_d = 16'h0;
				case (seq_q)
					S_START: begin
						seq_d = S_CTRLW;
						sh_d = {DEV_ADDR, 1'b0};
						cnt_d = 4'h0;
					end
					S_RSTART: begin
						seq_d = S_CTRLR;
						sh_d = {DEV_ADDR, 1'b1};
						cnt_d = 4'h0;
					end
					S_RDATA: begin
						if (cnt_q != 4'h8) begin
							sh_d = {sh_q[6:0], sda_s_q};
							cnt_d = 4'(cnt_q + 4'h1);
						end else begin
							data_d = sh_q;
							seq_d = S_STOP;
						end
					end
					S_STOP: begin
						seq_d = S_IDLE;
						ev[`SEAC_EV_DONE] = 1'b1;
					end
					S_CTRLW, S_AHI, S_ALO, S_WDATA, S_CTRLR: begin
						if (cnt_q != 4'h8) begin
							if (sh_q[7] && !sda_s_q && !iom_q) begin
								seq_d = S_IDLE;
								ev[`SEAC_EV_ARB] = 1'b1;
								ev[`SEAC_EV_DONE] = 1'b1;
							end else begin
								sh_d = {sh_q[6:0], 1'b1};
								cnt_d = 4'(cnt_q + 4'h1);
							end
						end else if (sda_s_q) begin
							seq_d = S_STOP;
							ev[`SEAC_EV_NACK] = 1'b1;
						end else begin
							cnt_d = 4'h0;
							case (seq_q)
								S_CTRLW: begin
									seq_d = S_AHI;
									sh_d = addr_q[15:8];
								end
								S_AHI: begin
									seq_d = S_ALO;
									sh_d = addr_q[7:0];
								end
								S_ALO: begin
									seq_d = op_q ? S_RSTART : S_WDATA;
									sh_d = data_q;
								end
								S_CTRLR: seq_d = S_RDATA;
								default: seq_d = S_STOP;
							endcase
						end
					end
					default: seq_d = S_IDLE;
				endcase
			end
		end
		// Hardware set wins over software clear
		done_d = (done_q & ~(wr_ee & wr_data_i[`SEAC_DONE_BIT])) | ev[`SEAC_EV_DONE];
		ist_d = (ist_q & ~(wr_ist ? wr_data_i[`SEAC_EV_MSB:0] : 4'h0)) | ev;
		if (run) begin
			// First slot keeps the clock high; its start is not tick aligned
			scl_oe_d = seq_d != S_IDLE && seq_d != S_START && pos_d < low_len(presc_q);
			sda_oe_d = seq_d != S_IDLE && want_low(kind_of(seq_d), pos_d, presc_q, tx_bit(seq_d, cnt_d, sh_d), sda_oe_q);
		end else begin
			// Stopped clock: both lines keep their level
			scl_oe_d = scl_oe_q;
			sda_oe_d = sda_oe_q;
		end
		chk_d = init_check_err_i && !ics_q;
		if (rd_en_i) begin
			case (addr_i)
				`SEAC_OFS_BUS_CTRL: begin
					rd_d[`SEAC_PRESC_MSB:0] = presc_q;
					rd_d[`SEAC_IOM_BIT] = iom_q;
					rd_d[`SEAC_ICS_BIT] = ics_q;
					rd_d[`SEAC_TOD_BIT] = tod_q;
				end
				`SEAC_OFS_EE_ACC: begin
					rd_d[`SEAC_ADDR_MSB:0] = addr_q;
					rd_d[`SEAC_DATA_MSB:`SEAC_DATA_LSB] = data_q;
					rd_d[`SEAC_BUSY_BIT] = busy;
					rd_d[`SEAC_DONE_BIT] = done_q;
					rd_d[`SEAC_OP_BIT] = op_q;
				end
				`SEAC_OFS_IRQ_STAT: rd_d[`SEAC_EV_MSB:0] = ist_q;
				`SEAC_OFS_IRQ_MASK: rd_d[`SEAC_EV_MSB:0] = imask_q;
				default: rd_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			seq_q <= S_IDLE;
			presc_q <= `SEAC_PRESC_RST;
			iom_q <= 1'b0;
			ics_q <= 1'b0;
			tod_q <= 1'b0;
			addr_q <= 16'h0;
			data_q <= 8'h0;
			op_q <= 1'b0;
			pos_q <= 16'h0;
			sh_q <= 8'h0;
			cnt_q <= 4'h0;
			done_q <= 1'b0;
			ist_q <= 4'h0;
			imask_q <= 4'h0;
			tmo_q <= 23'h0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			chk_q <= 1'b0;
			rd_q <= 32'h0;
		end else begin
			seq_q <= seq_d;
			presc_q <= presc_d;
			iom_q <= iom_d;
			ics_q <= ics_d;
			tod_q <= tod_d;
			addr_q <= addr_d;
			data_q <= data_d;
			op_q <= op_d;
			pos_q <= pos_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
			tmo_q <= tmo_d;
			scl_oe_q <= scl_oe_d;
			sda_oe_q <= sda_oe_d;
			chk_q <= chk_d;
			rd_q <= rd_d;
		end
	end

	// ==========================================================
	// Outputs
	assign rd_data_o = rd_q;
	assign irq_o = |(ist_q & imask_q);
	assign master_bus_clock_pin_o = 1'b0;
	assign master_bus_clock_pin_oe_o = scl_oe_q;
	assign master_bus_data_pin_o = 1'b0;
	assign master_bus_data_pin_oe_o = sda_oe_q;
	assign init_check_err_o = chk_q;
	assign timeout_disable_o = tod_q;
endmodule

// ===== logic/seac_defs.svh
// Offsets, field positions, reset values and timing counts of the EEPROM access block
`ifndef SEAC_DEFS_SVH
`define SEAC_DEFS_SVH
`define SEAC_OFS_BUS_CTRL 12'h428
`define SEAC_OFS_EE_ACC 12'h42c
`define SEAC_OFS_IRQ_STAT 12'h440
`define SEAC_OFS_IRQ_MASK 12'h444
`define SEAC_PRESC_MSB 15
`define SEAC_IOM_BIT 16
`define SEAC_ICS_BIT 17
`define SEAC_TOD_BIT 22
`define SEAC_ADDR_MSB 15
`define SEAC_DATA_LSB 16
`define SEAC_DATA_MSB 23
`define SEAC_BUSY_BIT 24
`define SEAC_DONE_BIT 25
`define SEAC_OP_BIT 26
`define SEAC_PRESC_RST 16'h0053
`define SEAC_EV_DONE 0
`define SEAC_EV_NACK 1
`define SEAC_EV_ARB 2
`define SEAC_EV_TMO 3
`define SEAC_EV_MSB 3
`define SEAC_CLK_NS 4
`define SEAC_BASE_NS 32
`define SEAC_BASE_CYC (`SEAC_BASE_NS / `SEAC_CLK_NS)
`define SEAC_TIMEOUT_NS 25000000
`define SEAC_TIMEOUT_CYC (`SEAC_TIMEOUT_NS / `SEAC_CLK_NS)
`endif

// ===== logic/seac_pkg.sv
// Types of the EEPROM access block
package seac_pkg;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_START = 4'h1,
		S_CTRLW = 4'h2,
		S_AHI = 4'h3,
		S_ALO = 4'h4,
		S_WDATA = 4'h5,
		S_RSTART = 4'h6,
		S_CTRLR = 4'h7,
		S_RDATA = 4'h8,
		S_STOP = 4'h9
	} seac_seq_t;
	typedef enum logic [1:0] {
		SL_BIT = 2'h0,
		SL_START = 2'h1,
		SL_STOP = 2'h2
	} seac_slot_t;
endpackage

// ===== dv/seac_ee_model.sv
// Behavioural serial EEPROM on the master bus
`timescale 1ns/100ps
module seac_ee_model (
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_pull_o
);
	logic [7:0] mem [0:255];
	logic [7:0] sh, ad, ob;
	logic rd, tx;
	int bc, nb;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
		sda_pull_o = 1'b0;
		rd = 1'b0;
		bc = 0;
		nb = 0;
	end
	// ==========
	// Start and stop framing
	always @(negedge sda_i) if (scl_i) begin
		bc = 0;
		nb = 0;
		rd = 1'b0;
	end
	always @(posedge sda_i) if (scl_i) begin
		bc = 0;
		nb = 0;
	end
	// ==========
	// Bit shifting, ack and read data
	always @(posedge scl_i) begin
		if (bc < 8) sh = {sh[6:0], sda_i};
		bc = bc + 1;
	end
	always @(negedge scl_i) begin
		tx = rd && nb > 0;
		if (bc == 8 && !tx) begin
			if (nb == 0) rd = sh[0];
			if (nb == 2) ad = sh;
			if (nb >= 3) mem[ad] = sh;
			nb = nb + 1;
			sda_pull_o = 1'b1;
		end else if (bc == 8) begin
			rd = 1'b0;
			sda_pull_o = 1'b0;
		end else begin
			if (bc == 9) bc = 0;
			if (tx && bc == 0) ob = mem[ad];
			sda_pull_o = tx && !ob[7 - bc];
		end
	end
endmodule

// ===== dv/seac_ctrl_sva.sv
// Port assertions of the EEPROM access block
`timescale 1ns/100ps
module seac_ctrl_sva (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic [11:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [31:0] rd_data_o,
	input wire logic irq_o,
	input wire logic master_bus_clock_pin_oe_o,
	input wire logic master_bus_data_pin_oe_o,
	input wire logic init_check_err_i,
	input wire logic init_check_err_o,
	input wire logic timeout_disable_o
);
	// ==========
	// Shadow settings and low-phase counter
	logic [22:0] bc_q, bc_d;
	logic [3:0] msk_q, msk_d;
	logic [19:0] lo_q, lo_d, h8;
	always_comb begin
		bc_d = bc_q;
		msk_d = msk_q;
		if (wr_en_i && addr_i == 12'h428) bc_d = wr_data_i[22:0] & 23'h43ffff;
		if (wr_en_i && addr_i == 12'h444) msk_d = wr_data_i[3:0];
		lo_d = master_bus_clock_pin_oe_o ? lo_q + 20'h1 : 20'h0;
		h8 = {1'b0, bc_q[15:0] - {1'b0, bc_q[15:1]}, 3'h0};
	end
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bc_q <= 23'h53;
			msk_q <= 4'h0;
			lo_q <= 20'h0;
		end else begin
			bc_q <= bc_d;
			msk_q <= msk_d;
			lo_q <= lo_d;
		end
	end
	// ==========
	// Assertions
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);
	a_rd_idle_zero: assert property (!$past(rd_en_i) |-> rd_data_o == 32'h0)
		else $error("read data outside read");
	a_ctl_readback: assert property ($past(rd_en_i && addr_i == 12'h428) |-> rd_data_o == {9'h0, bc_q})
		else $error("bus control readback");
	a_acc_reserved: assert property ($past(rd_en_i && addr_i == 12'h42c) |-> rd_data_o[31:27] == 5'h0)
		else $error("access reserved bits");
	a_chk_ignore: assert property (init_check_err_o == ($past(init_check_err_i) && !$past(bc_q[17])))
		else $error("checksum error gating");
	a_tmo_follow: assert property (wr_en_i && addr_i == 12'h428 |=> ##2 timeout_disable_o == bc_q[22])
		else $error("timeout disable output");
	a_irq_masked: assert property (msk_q == 4'h0 |-> !irq_o)
		else $error("irq while masked");
	a_presc_stop: assert property (bc_q[15:1] == 15'h0 && $past(bc_q[15:1], 2) == 15'h0 |->
		$stable(master_bus_clock_pin_oe_o) && $stable(master_bus_data_pin_oe_o)) else $error("clock not stopped");
	a_clk_low_min: assert property ($fell(master_bus_clock_pin_oe_o) |-> lo_q >= h8)
		else $error("clock low too short");
endmodule
bind seac_ctrl seac_ctrl_sva chk (.*);

// ===== dv/tb_top.sv
// Self-checking bench of the EEPROM access block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; $display("ERROR %s exp %h got %h", nm, ex, got); end end
module tb_top;
	logic mclk_i = 1'b0, rst_b_i = 1'b0, wr_en_i = 1'b0, rd_en_i = 1'b0, init_check_err_i = 1'b0, msk = 1'b0;
	logic [11:0] addr_i = 12'h0;
	logic [31:0] wr_data_i = 32'h0, rd_data_o, v, r;
	logic irq_o, master_bus_clock_pin_o, master_bus_clock_pin_oe_o, master_bus_data_pin_o, master_bus_data_pin_oe_o;
	logic init_check_err_o, timeout_disable_o, pull;
	logic [7:0] mem [0:255];
	int fails = 0, n_checks = 0;
	wire master_bus_clock_pin_i = !master_bus_clock_pin_oe_o;
	wire master_bus_data_pin_i = !(master_bus_data_pin_oe_o || pull);
	seac_ctrl #(.TIMEOUT_CYCLES(200)) dut (.*);
	seac_ee_model ee (.scl_i(master_bus_clock_pin_i), .sda_i(master_bus_data_pin_i), .sda_pull_o(pull));
	initial forever #2 mclk_i = !mclk_i;
	function automatic logic [7:0] exp_byte(input logic kind, input logic [15:0] a, input logic [7:0] d);
		return kind ? mem[a[7:0]] : d;
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_en_i <= 1'b1;
		@(posedge mclk_i);
		wr_en_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge mclk_i);
		rd_en_i <= 1'b0;
		#1 d = rd_data_o;
	endtask
	// ==========
	// One EEPROM operation, optionally stalled by a zero prescaler
	task automatic op(input logic kind, input logic [15:0] a, input logic [7:0] d, input logic frz);
		int n;
		n = 0;
		wr(12'h42c, {5'h0, kind, 2'h0, d, a});
		wr(12'h42c, 32'h0200_0000);
		rd(12'h42c, v);
		`CHK("busy", 2'b01, v[25:24])
		`CHK("addr", a, v[15:0])
		if (frz) begin
			wr(12'h428, 32'h0);
			repeat (100) @(posedge mclk_i);
			rd(12'h42c, v);
			`CHK("frozen", 1'b1, v[24])
			wr(12'h428, 32'h4);
		end
		do begin
			rd(12'h42c, v);
			n++;
		end while (v[24] === 1'b1 && n < 3000);
		`CHK("done", 2'b10, v[25:24])
		`CHK("data", exp_byte(kind, a, d), v[23:16])
		if (!kind) mem[a[7:0]] = d;
		`CHK("irq", msk, irq_o)
		wr(12'h440, 32'h1);
		@(posedge mclk_i);
		#1 `CHK("irq clear", 1'b0, irq_o)
		repeat (100) @(posedge mclk_i);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge mclk_i);
		fails++;
		final_report;
	end
	// ==========
	// Main sequence
	initial begin
		void'($urandom(32'hba392f5c));
		for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
		repeat (3) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		rd(12'h428, v);
		`CHK("ctl reset", 32'h0000_0053, v)
		rd(12'h42c, v);
		`CHK("acc reset", 32'h0, v)
		rd(12'h400, v);
		`CHK("unmapped", 32'h0, v)
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			wr(12'h428, r);
			init_check_err_i <= 1'b1;
			rd(12'h428, v);
			`CHK("ctl rw", r & 32'h0043_ffff, v)
			`CHK("chk err", !r[17], init_check_err_o)
			`CHK("tmo dis", r[22], timeout_disable_o)
		end
		init_check_err_i <= 1'b0;
		$display("test control done");
		wr(12'h428, 32'h4);
		r = $urandom;
		op(1'b0, r[15:0], r[23:16], 1'b0);
		wr(12'h444, 32'h1);
		msk = 1'b1;
		op(1'b0, r[15:0] + 16'h1, ~r[23:16], 1'b1);
		op(1'b1, r[15:0], r[31:24], 1'b0);
		op(1'b1, r[15:0] + 16'h1, r[7:0], 1'b0);
		op(1'b1, 16'hffff, r[31:24], 1'b0);
		$display("test eeprom done");
		final_report;
	end
endmodule
